// file: logic/cbr_regs_top.sv
// Serial bus control and status register bank of a clock fan-out buffer
`timescale 1ns/10ps

// Overview of operation
// R1: Cleared output enable bit forces that pair low whatever its enable pin says.
// R2: Byte 1 bits 7:6 read back the mode strap captured at power good.
// R3: Byte 1 bit 5 picks strapped mode (0) or software mode bits (1).
// R4: Software mode bits 4:3 reset to 0 and act only when bit 5 is 1.
// R5: Byte 1 bits 1:0 choose output amplitude 0.6 to 0.9 V, reset 10.
// R6: Byte 2 bits 6,5,3,1 set edge rate of pairs 3,2,1,0; reset 1.
// R7: Byte 3 bit 5 enables software frequency change, reset 0.
// R8: Frequency bits 4:3 reset 0 and act only when byte 3 bit 5 is 1.
// R9: Byte 3 bit 0 sets feedback edge rate, reset 1.
// R10: Byte 4 always reads all ones.
// R11: Byte 5 reads fixed revision code high, maker code low.
// R12: Byte 6 reads fixed family code in 7:6, part number in 5:0.
// R13: Byte 7 bits 4:0 set block read length, reset 8; 7:5 reserved.
// R14: Block write: address, index, count, data bytes; every byte acknowledged.
// R15: Block read: index write, repeated start, count then data from index.
// R16: Bus address latched from three level strap: 6B, 6C or 6D.
// R17: Reserved bits ignore writes and read their default or one.
module cbr_regs_top
  import cbr_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE    = 4'h3, // Arbitrary value
  parameter logic [3:0] MAKER_CODE       = 4'hA, // Arbitrary value
  parameter logic [1:0] PART_FAMILY_CODE = 2'h2, // Arbitrary value
  parameter logic [5:0] PART_NUMBER_CODE = 6'h15 // Arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       power_good_powerdown_n,
  input  wire logic [1:0] address_strap,
  input  wire logic [1:0] pll_mode_strap,
  input  wire logic [3:0] oe_pin_n,
  output logic [3:0]      clock_output_pair_run,
  output logic [3:0]      edge_rate_out,
  output logic            feedback_edge_rate,
  output logic [1:0]      amplitude_sel,
  output logic [1:0]      pll_mode,
  output logic [1:0]      freq_choice
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cbr_state_type state_ff;
  logic [7:0]    cfg_ff [0:NUM_REGS-1];
  logic [7:0]    index_ff;
  logic [7:0]    tx_byte_ff;
  logic          tx_mode_ff;
  logic          ack_req_ff;
  logic          captured_ff;
  logic [6:0]    bus_addr_ff;
  logic [1:0]    pll_strap_ff;
  logic [3:0]    pair_run_ff;
  logic [3:0]    edge_ff;
  logic          fb_edge_ff;
  logic [1:0]    amp_ff;
  logic [1:0]    mode_ff;
  logic [1:0]    freq_ff;
  logic [7:0]    rd_data;
  logic [6:0]    nxt_addr;
  logic          wr_pls;
  logic          start_pls;
  logic          stop_pls;
  logic          byte_pls;
  logic [7:0]    rx_byte;
  logic          ack_pls;
  logic          host_ack;

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  cbr_bit_engine u_bits (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .ack_req   (ack_req_ff),
    .tx_mode   (tx_mode_ff),
    .tx_byte   (tx_byte_ff),
    .start_pls (start_pls),
    .stop_pls  (stop_pls),
    .byte_pls  (byte_pls),
    .rx_byte   (rx_byte),
    .ack_pls   (ack_pls),
    .host_ack  (host_ack),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe)
  );

  // ----------------------------------------------------------------
  // Strap capture at the first power good
  // ----------------------------------------------------------------
  // Three level strap decode; any code above mid is taken as high
  always_comb begin
    nxt_addr = ADDR_HIGH;
    if (address_strap == STRAP_LOW) begin
      nxt_addr = ADDR_LOW;
    end else if (address_strap == STRAP_MID) begin
      nxt_addr = ADDR_MID;
    end
  end

  // Captured once, so later strap movement cannot move the address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      captured_ff  <= 1'b0;
      bus_addr_ff  <= 7'h00;
      pll_strap_ff <= 2'h0;
    end else if (power_good_powerdown_n && !captured_ff) begin
      captured_ff  <= 1'b1;
      bus_addr_ff  <= nxt_addr; // [R16]
      pll_strap_ff <= pll_mode_strap; // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Register storage, one entry per index
  // ----------------------------------------------------------------
  assign wr_pls = byte_pls && state_ff == ST_WDATA;

  // Only writable bits take data; the rest keep their fixed value
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cfg_ff[g] <= RST_VAL[g]; // [R4] [R5] [R6] [R7] [R8] [R9] [R13]
      end else if (wr_pls && index_ff == 8'(g)) begin
        cfg_ff[g] <= (rx_byte & RW_MASK[g]) | (cfg_ff[g] & ~RW_MASK[g]); // [R17]
      end
    end
  end

  // Read data by index; unmapped indexes read zero
  always_comb begin
    rd_data = UNMAPPED_READ;
    unique case (index_ff)
      IDX_OUT_EN:    rd_data = cfg_ff[0];
      IDX_PLL_AMP:   rd_data = {pll_strap_ff, cfg_ff[1][5:0]}; // [R2]
      IDX_EDGE:      rd_data = cfg_ff[2];
      IDX_FREQ:      rd_data = cfg_ff[3];
      IDX_RSVD:      rd_data = RSVD_READ; // [R10]
      IDX_REV_MAKER: rd_data = {REVISION_CODE, MAKER_CODE}; // [R11]
      IDX_PART:      rd_data = {PART_FAMILY_CODE, PART_NUMBER_CODE}; // [R12]
      IDX_COUNT:     rd_data = cfg_ff[7];
      default:       rd_data = UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // Every byte received after an address match is acknowledged; the index
  // advances per data byte in both directions
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      index_ff   <= 8'h00;
      tx_byte_ff <= 8'h00;
      tx_mode_ff <= 1'b0;
      ack_req_ff <= 1'b0;
    end else if (start_pls) begin
      state_ff   <= ST_ADDR;
      tx_mode_ff <= 1'b0;
      ack_req_ff <= 1'b0;
    end else if (stop_pls) begin
      state_ff   <= ST_IDLE;
      tx_mode_ff <= 1'b0;
      ack_req_ff <= 1'b0;
    end else if (byte_pls && !tx_mode_ff) begin
      unique case (state_ff)
        ST_ADDR: begin
          if (rx_byte[7:1] == bus_addr_ff && captured_ff) begin
            ack_req_ff <= 1'b1;
            if (rx_byte[0]) begin
              // Read: the count goes first, then bytes from the index
              state_ff   <= ST_RDATA;
              tx_mode_ff <= 1'b1;
              tx_byte_ff <= {3'h0, cfg_ff[7][COUNT_MSB:0]}; // [R13] [R15]
            end else begin
              state_ff <= ST_INDEX;
            end
          end else begin
            state_ff   <= ST_IGNORE;
            ack_req_ff <= 1'b0;
          end
        end
        ST_INDEX: begin
          index_ff   <= rx_byte; // [R14]
          state_ff   <= ST_WCOUNT;
          ack_req_ff <= 1'b1;
        end
        ST_WCOUNT: begin
          // The count is taken but not enforced; stop ends the write
          state_ff   <= ST_WDATA;
          ack_req_ff <= 1'b1;
        end
        ST_WDATA: begin
          index_ff   <= index_ff + 8'h01;
          ack_req_ff <= 1'b1; // [R14]
        end
        ST_IDLE, ST_IGNORE, ST_RDATA: begin
          ack_req_ff <= 1'b0;
        end
      endcase
    end else if (ack_pls && state_ff == ST_RDATA) begin
      if (host_ack) begin
        tx_byte_ff <= rd_data; // [R15]
        index_ff   <= index_ff + 8'h01;
      end else begin
        state_ff   <= ST_IDLE;
        tx_mode_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the clock path
  // ----------------------------------------------------------------
  // Power good low or a cleared enable bit holds the pair low/low
  for (genvar p = 0; p < 4; p++) begin : g_pair
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        pair_run_ff[p] <= 1'b0;
        edge_ff[p]     <= 1'b1;
      end else begin
        pair_run_ff[p] <= power_good_powerdown_n & cfg_ff[0][OUT_BIT[p]]
                          & ~oe_pin_n[p]; // [R1]
        edge_ff[p]     <= cfg_ff[2][OUT_BIT[p]]; // [R6]
      end
    end
  end

  // Mode and frequency follow software only while their enables are set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      amp_ff     <= RST_VAL[1][AMP_LSB+:2];
      fb_edge_ff <= 1'b1;
      mode_ff    <= 2'h0;
      freq_ff    <= FREQ_OFF;
    end else begin
      amp_ff     <= cfg_ff[1][AMP_LSB+:2]; // [R5]
      fb_edge_ff <= cfg_ff[3][FB_EDGE_BIT]; // [R9]
      mode_ff    <= cfg_ff[1][PLL_SW_SEL_BIT] ? cfg_ff[1][PLL_CTL_LSB+:2]
                                              : pll_strap_ff; // [R3] [R4]
      freq_ff    <= cfg_ff[3][FREQ_EN_BIT] ? cfg_ff[3][FREQ_LSB+:2]
                                           : FREQ_OFF; // [R7] [R8]
    end
  end

  assign clock_output_pair_run = pair_run_ff;
  assign edge_rate_out         = edge_ff;
  assign feedback_edge_rate    = fb_edge_ff;
  assign amplitude_sel         = amp_ff;
  assign pll_mode              = mode_ff;
  assign freq_choice           = freq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_data_byte;
    byte_pls && !tx_mode_ff && state_ff == ST_WDATA;
  endsequence

  sequence s_read_addr;
    byte_pls && !tx_mode_ff && state_ff == ST_ADDR && captured_ff
      && rx_byte == {bus_addr_ff, 1'b1};
  endsequence

  chk_pair_forced_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    !cfg_ff[0][OUT_BIT[0]] || !power_good_powerdown_n |=> !clock_output_pair_run[0])
    else $error("pair 0 runs while disabled");

  chk_strap_readback: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
    index_ff == IDX_PLL_AMP |-> rd_data[7:6] == pll_strap_ff)
    else $error("mode readback differs from strap");

  chk_mode_source: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    ##1 pll_mode == ($past(cfg_ff[1][5]) ? $past(cfg_ff[1][4:3]) : $past(pll_strap_ff)))
    else $error("mode source wrong");

  chk_amp_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
    $changed(cfg_ff[1][1:0]) |=> amplitude_sel == $past(cfg_ff[1][1:0]))
    else $error("amplitude not applied");

  chk_edge_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    ##1 edge_rate_out[3] == $past(cfg_ff[2][6]) && feedback_edge_rate == $past(cfg_ff[3][0]))
    else $error("edge rate not applied");

  chk_freq_gated: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    !cfg_ff[3][5] [*2] |-> freq_choice == FREQ_OFF)
    else $error("frequency changed while disabled");

  chk_rsvd_ones: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
    index_ff == IDX_RSVD |-> rd_data == 8'hFF)
    else $error("reserved byte not all ones");

  chk_write_ack: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R14]
    s_data_byte |=> ack_req_ff)
    else $error("data byte not acknowledged");

  chk_read_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
    s_read_addr ##1 !start_pls |-> tx_mode_ff && tx_byte_ff == {3'h0, cfg_ff[7][4:0]})
    else $error("read did not start with count");

  chk_rsvd_kept: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R17]
    ##1 (cfg_ff[7][7:5] == 3'h7 && cfg_ff[1][2] && cfg_ff[3][7:6] == 2'h3))
    else $error("reserved bit changed");

endmodule

// file: logic/cbr_pkg.sv
// Constants, register map and state type for the clock buffer register bank
package cbr_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OUT_EN     = 8'h00;
  localparam logic [7:0] IDX_PLL_AMP    = 8'h01;
  localparam logic [7:0] IDX_EDGE       = 8'h02;
  localparam logic [7:0] IDX_FREQ       = 8'h03;
  localparam logic [7:0] IDX_RSVD       = 8'h04;
  localparam logic [7:0] IDX_REV_MAKER  = 8'h05;
  localparam logic [7:0] IDX_PART       = 8'h06;
  localparam logic [7:0] IDX_COUNT      = 8'h07;
  localparam int         NUM_REGS       = 8;

  // ----------------------------------------------------------------
  // Writable bits and reset values per index
  // ----------------------------------------------------------------
  localparam logic [7:0] RW_MASK [0:7] = '{8'h6A, 8'h3B, 8'h6A, 8'h39,
                                           8'h00, 8'h00, 8'h00, 8'h1F};
  localparam logic [7:0] RST_VAL [0:7] = '{8'hFF, 8'h06, 8'hFF, 8'hC7,
                                           8'hFF, 8'h00, 8'h00, 8'hE8};
  localparam logic [7:0] RSVD_READ      = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT_BIT [0:3]   = '{1, 3, 5, 6};
  localparam int PLL_SW_SEL_BIT  = 5;
  localparam int PLL_CTL_LSB     = 3;
  localparam int PLL_RB_LSB      = 6;
  localparam int AMP_LSB         = 0;
  localparam int FREQ_EN_BIT     = 5;
  localparam int FREQ_LSB        = 3;
  localparam int FB_EDGE_BIT     = 0;
  localparam int COUNT_MSB       = 4;
  localparam logic [1:0] FREQ_OFF = 2'h0;

  // ----------------------------------------------------------------
  // Bus address strap decode
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_MID  = 2'h1;
  localparam logic [6:0] ADDR_LOW   = 7'h6B;
  localparam logic [6:0] ADDR_MID   = 7'h6C;
  localparam logic [6:0] ADDR_HIGH  = 7'h6D;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_WCOUNT, ST_WDATA, ST_RDATA, ST_IGNORE
  } cbr_state_type;

endpackage

// file: logic/cbr_bit_engine.sv
// Bit level serial bus engine: start/stop, byte shift and acknowledge drive
`timescale 1ns/10ps
module cbr_bit_engine
  import cbr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_req,
  input  wire logic       tx_mode,
  input  wire logic [7:0] tx_byte,
  output logic            start_pls,
  output logic            stop_pls,
  output logic            byte_pls,
  output logic [7:0]      rx_byte,
  output logic            ack_pls,
  output logic            host_ack,
  output logic            sda_out,
  output logic            sda_oe
);

  logic       scl_ff;
  logic       sda_ff;
  logic [3:0] cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic       cur_rx_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       is_start;
  logic       is_stop;

  // Line edges; SDA moving while SCL is high frames a transfer
  assign scl_rise = ~scl_ff & scl_in;
  assign scl_fall = scl_ff & ~scl_in;
  assign is_start = scl_ff & scl_in & sda_ff & ~sda_in;
  assign is_stop  = scl_ff & scl_in & ~sda_ff & sda_in;

  // ----------------------------------------------------------------
  // Sampling and event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_ff    <= 1'b1;
      sda_ff    <= 1'b1;
      start_pls <= 1'b0;
      stop_pls  <= 1'b0;
      byte_pls  <= 1'b0;
      ack_pls   <= 1'b0;
      host_ack  <= 1'b0;
      rx_sh_ff  <= 8'h00;
      sda_out   <= 1'b0;
    end else begin
      scl_ff    <= scl_in;
      sda_ff    <= sda_in;
      start_pls <= is_start;
      stop_pls  <= is_stop;
      byte_pls  <= scl_rise && cnt_ff == LAST_BIT;
      ack_pls   <= scl_rise && cnt_ff == ACK_SLOT && !cur_rx_ff;
      if (scl_rise && cnt_ff == ACK_SLOT) begin
        host_ack <= ~sda_in; // Low in the ninth slot is an acknowledge
      end
      if (scl_rise && cnt_ff < ACK_SLOT) begin
        rx_sh_ff <= {rx_sh_ff[6:0], sda_in};
      end
    end
  end

  assign rx_byte = rx_sh_ff;

  // Bit counter, zero at the first data bit of each byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (is_start || is_stop) begin
      cnt_ff <= 4'h0;
    end else if (scl_rise) begin
      cnt_ff <= (cnt_ff == ACK_SLOT) ? 4'h0 : cnt_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive, changed only while SCL is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_oe    <= 1'b0;
      cur_rx_ff <= 1'b1;
      tx_sh_ff  <= 8'h00;
    end else if (is_start || is_stop) begin
      sda_oe    <= 1'b0;
      cur_rx_ff <= 1'b1;
    end else if (scl_fall) begin
      if (cnt_ff == ACK_SLOT) begin
        sda_oe <= cur_rx_ff & ack_req; // [R14] [R15]
      end else if (cnt_ff == 4'h0) begin
        // Direction is chosen per byte so an address ack precedes read data
        cur_rx_ff <= ~tx_mode;
        sda_oe    <= tx_mode & ~tx_byte[7];
        tx_sh_ff  <= {tx_byte[6:0], 1'b0};
      end else begin
        sda_oe    <= ~cur_rx_ff & ~tx_sh_ff[7];
        tx_sh_ff  <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

endmodule

// file: verification/cbr_host_model.sv
// Serial bus host model that issues indexed block transfers
`timescale 1ns/10ps
module cbr_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl_out,
  output logic      sda_pull
);
  logic [7:0] rx_val;
  event       got;

  // ----------------------------------------------------------------
  // Line control
  // ----------------------------------------------------------------
  // Both lines start released; the pull-up holds them high
  initial begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
    rx_val   = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One bit slot; data moves only while the clock line is low
  task automatic bit_slot(input logic b, output logic r);
    tick(1);
    sda_pull = ~b;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    r = sda_line;
    scl_out = 1'b0;
    tick(3);
  endtask

  // Start or repeated start: data falls while the clock line is high
  task automatic start_cond();
    sda_pull = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl_out = 1'b0;
    tick(4);
  endtask

  // Stop: data rises while the clock line is high, both lines left released
  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Byte transfers
  // ----------------------------------------------------------------
  // Byte out MSB first; reports 01 when the device acknowledged
  task automatic send_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    rx_val = {7'h00, ~r};
    ->got;
  endtask

  // Byte in MSB first; the host acknowledges all but the last
  task automatic recv_byte(input logic last);
    logic       r;
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_slot(1'b1, r);
      v = {v[6:0], r};
    end
    bit_slot(last, r);
    rx_val = v;
    ->got;
  endtask
endmodule

// file: verification/test_clock_buffer_smbus_control_regs.sv
// Self-checking bench for the clock buffer control register bank
`timescale 1ns/10ps
`define CHK(got_v, exp_v) begin \
  comparisons++; \
  if ((got_v) !== (exp_v)) begin \
    n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got_v), (exp_v)); \
  end \
end

module test_clock_buffer_smbus_control_regs
  import cbr_pkg::*;
;
  // Identity values are arbitrary, chosen only to differ from the defaults
  localparam logic [3:0] REV  = 4'h6;
  localparam logic [3:0] MAKR = 4'h9;
  localparam logic [1:0] FAM  = 2'h3;
  localparam logic [5:0] PNUM = 6'h2E;
  localparam logic [6:0] ADDR_TAB [0:2] = '{7'h6B, 7'h6C, 7'h6D};
  localparam logic [7:0] DEF [0:7] = '{8'hFF, 8'h06, 8'hFF, 8'hC7,
                                       8'hFF, 8'h00, 8'h00, 8'hE8};
  localparam logic [7:0] WMSK [0:7] = '{8'h6A, 8'h3B, 8'h6A, 8'h39,
                                        8'h00, 8'h00, 8'h00, 8'h1F};
  localparam int OBIT [0:3] = '{1, 3, 5, 6};

  logic       clk_sys;
  logic       rst_n      = 1'b0;
  logic       scl;
  logic       sda_pull;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       pgood      = 1'b0;
  logic [1:0] addr_strap = 2'h0;
  logic [1:0] mode_strap = 2'h0;
  logic [3:0] oe_pin_n   = 4'h0;
  logic [3:0] pair_run;
  logic [3:0] edge_rate;
  logic       fb_edge;
  logic [1:0] amp;
  logic [1:0] pll_mode;
  logic [1:0] freq;
  logic [7:0] regs_exp [0:7];
  logic [7:0] wr_d [0:7];
  logic [7:0] exp_q [$];
  logic [7:0] exp_v;
  int         n_mismatch  = 0;
  int         comparisons = 0;
  int         cyc         = 0;

  // ----------------------------------------------------------------
  // Device, host and wire
  // ----------------------------------------------------------------
  // Open-drain data wire: low if either party pulls, else the pull-up wins
  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_out);

  cbr_regs_top #(
    .REVISION_CODE   (REV),
    .MAKER_CODE      (MAKR),
    .PART_FAMILY_CODE(FAM),
    .PART_NUMBER_CODE(PNUM)
  ) uut (
    .clk_sys               (clk_sys),
    .rst_n                 (rst_n),
    .scl_in                (scl),
    .sda_in                (sda_line),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .power_good_powerdown_n(pgood),
    .address_strap         (addr_strap),
    .pll_mode_strap        (mode_strap),
    .oe_pin_n              (oe_pin_n),
    .clock_output_pair_run (pair_run),
    .edge_rate_out         (edge_rate),
    .feedback_edge_rate    (fb_edge),
    .amplitude_sel         (amp),
    .pll_mode              (pll_mode),
    .freq_choice           (freq)
  );

  cbr_host_model host (
    .clk_sys (clk_sys),
    .sda_line(sda_line),
    .scl_out (scl),
    .sda_pull(sda_pull)
  );

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Hang guard, about two and a half times the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Reset with straps set; capture happens once power good rises
  task automatic do_reset(input logic [1:0] s, input logic [1:0] m);
    tick(1);
    rst_n = 1'b0;
    pgood = 1'b0;
    addr_strap = s;
    mode_strap = m;
    oe_pin_n = 4'h0;
    tick(20);
    rst_n = 1'b1;
    tick(2);
    pgood = 1'b1;
    tick(4);
    for (int k = 0; k < 8; k++) regs_exp[k] = DEF[k];
    regs_exp[1][7:6] = m;
    regs_exp[5] = {REV, MAKR};
    regs_exp[6] = {FAM, PNUM};
  endtask

  // Port levels worked out from the expected register image
  task automatic check_ports();
    logic [1:0] pm;
    pm = regs_exp[1][5] ? regs_exp[1][4:3] : regs_exp[1][7:6];
    for (int p = 0; p < 4; p++) begin
      `CHK(pair_run[p], pgood & regs_exp[0][OBIT[p]] & ~oe_pin_n[p])
      `CHK(edge_rate[p], regs_exp[2][OBIT[p]])
    end
    `CHK(fb_edge, regs_exp[3][0])
    `CHK(amp, regs_exp[1][1:0])
    `CHK(pll_mode, pm)
    `CHK(freq, regs_exp[3][5] ? regs_exp[3][4:3] : 2'h0)
  endtask

  // Block write of wr_d to bytes 0..7, every byte acknowledged
  task automatic blk_write(input logic [6:0] a);
    for (int k = 0; k < 11; k++) exp_q.push_back(8'h01);
    host.start_cond();
    host.send_byte({a, 1'b0});
    host.send_byte(8'h00);
    host.send_byte(8'h08);
    for (int k = 0; k < 8; k++) begin
      host.send_byte(wr_d[k]);
      regs_exp[k] = (wr_d[k] & WMSK[k]) | (regs_exp[k] & ~WMSK[k]);
    end
    host.stop_cond();
    tick(4);
  endtask

  // Block read: count byte first, then n bytes from idx; unmapped read 00
  task automatic blk_read(input logic [6:0] a, input logic [7:0] idx, input int n);
    for (int k = 0; k < 3; k++) exp_q.push_back(8'h01);
    exp_q.push_back({3'h0, regs_exp[7][4:0]});
    for (int k = 0; k < n; k++) begin
      exp_v = (idx + k < 8) ? regs_exp[idx + k] : 8'h00;
      exp_q.push_back(exp_v);
    end
    host.start_cond();
    host.send_byte({a, 1'b0});
    host.send_byte(idx);
    host.start_cond();
    host.send_byte({a, 1'b1});
    // Count byte plus n data bytes; only the last one is refused
    for (int k = 0; k <= n; k++) host.recv_byte(k == n);
    host.stop_cond();
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Result monitor and main sequence
  // ----------------------------------------------------------------
  // Each result reported by the host is matched with the oldest note
  initial begin
    logic [7:0] note;
    forever begin
      @(host.got);
      note = (exp_q.size() == 0) ? 8'hXX : exp_q.pop_front();
      `CHK(host.rx_val, note)
    end
  end

  initial begin
    int unused_seed;
    unused_seed = $urandom(33817);
    for (int s = 0; s < 3; s++) begin
      // Top strap also tries code 3, which must decode as high
      do_reset((s == 2) ? 2'(2 + $urandom_range(1)) : 2'(s), 2'($urandom));
      check_ports();
      $display("Reset values checked, strap %0d", s);
      // Another strap's address must go unanswered
      exp_q.push_back(8'h00);
      host.start_cond();
      host.send_byte({ADDR_TAB[(s + 1) % 3], 1'b0});
      host.stop_cond();
      blk_read(ADDR_TAB[s], 8'h00, 8);
      for (int i = 0; i < 4; i++) begin
        for (int k = 0; k < 8; k++) wr_d[k] = 8'($urandom);
        wr_d[1][1:0] = 2'(i);
        wr_d[1][5] = i[0];
        wr_d[3][5] = i[1];
        oe_pin_n = 4'($urandom);
        blk_write(ADDR_TAB[s]);
        check_ports();
        blk_read(ADDR_TAB[s], 8'h00, 8);
      end
      $display("Write and read back checked, strap %0d", s);
      blk_read(ADDR_TAB[s], 8'h08, 2);
      pgood = 1'b0;
      tick(4);
      `CHK(pair_run, 4'h0)
      $display("Unmapped read and power down checked, strap %0d", s);
    end
    tick(10);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
